/* File: core/adc_out_cfg_pkg.sv */
/*
 * constants for the output path configuration bank: register offsets,
 * field positions, reset values, test codes and pattern words.
 * assumes a 16-bit register address and 8-bit register data.
 */
`default_nettype none
package adc_out_cfg_pkg;
   localparam int NUM_CH = 4; // data channels a..d
   localparam int DATA_W = 14; // converted sample width
   localparam int LANE_W = 16; // serialised word width
   localparam int PN_LONG_W = 23; // long generator length
   localparam int PN_LONG_TAP = 18; // long generator tap
   localparam int PN_SHORT_W = 9; // short generator length
   localparam int PN_SHORT_TAP = 5; // short generator tap
   // register offsets
   localparam logic [15:0] ADDR_CHAN_INDEX = 16'h0005;
   localparam logic [15:0] ADDR_CLK_DIV = 16'h000b;
   localparam logic [15:0] ADDR_ENH = 16'h000c;
   localparam logic [15:0] ADDR_TEST = 16'h000d;
   localparam logic [15:0] ADDR_OFFSET = 16'h0010;
   localparam logic [15:0] ADDR_OUT_FMT = 16'h0014;
   localparam logic [15:0] ADDR_OUT_DRV = 16'h0015;
   localparam logic [15:0] ADDR_OUT_PHASE = 16'h0016;
   localparam logic [15:0] ADDR_UPAT1_LO = 16'h0019;
   localparam logic [15:0] ADDR_UPAT1_HI = 16'h001a;
   localparam logic [15:0] ADDR_UPAT2_LO = 16'h001b;
   localparam logic [15:0] ADDR_UPAT2_HI = 16'h001c;
   // reset values
   localparam logic [5:0] CHAN_SEL_RST = 6'h3f;
   localparam logic [7:0] OUT_FMT_RST = 8'h01;
   localparam logic [7:0] OUT_PHASE_RST = 8'h03;
   // field positions
   localparam int CHOP_BIT = 2;
   localparam int PN_LONG_RST_BIT = 5;
   localparam int PN_SHORT_RST_BIT = 4;
   localparam int UMODE_LSB = 6;
   localparam int FMT_BIT = 0;
   localparam int INV_BIT = 2;
   localparam int LVDS_BIT = 6;
   localparam int DRIVE_BIT = 0;
   localparam int TERM_LSB = 4;
   localparam int PH_DLY_LSB = 4;
   localparam logic [3:0] PHASE_ADJ_MAX = 4'hb; // highest legal code
   localparam logic [2:0] DIV_CODE_MAX = 3'h6; // divide by seven
   localparam logic [DATA_W-1:0] DATA_MAX = 14'h3fff;
   // test selection codes
   localparam logic [3:0] TEST_OFF = 4'h0;
   localparam logic [3:0] TEST_MID = 4'h1;
   localparam logic [3:0] TEST_POS_FS = 4'h2;
   localparam logic [3:0] TEST_NEG_FS = 4'h3;
   localparam logic [3:0] TEST_CHECKER = 4'h4;
   localparam logic [3:0] TEST_PN_LONG = 4'h5;
   localparam logic [3:0] TEST_PN_SHORT = 4'h6;
   localparam logic [3:0] TEST_WORD_TOG = 4'h7;
   localparam logic [3:0] TEST_USER = 4'h8;
   localparam logic [3:0] TEST_BIT_TOG = 4'h9;
   localparam logic [3:0] TEST_SYNC = 4'ha;
   localparam logic [3:0] TEST_ONE_BIT = 4'hb;
   // user test modes
   localparam logic [1:0] UMODE_REPEAT = 2'h0;
   localparam logic [1:0] UMODE_ALT = 2'h1;
   localparam logic [1:0] UMODE_ONCE = 2'h2;
   localparam logic [1:0] UMODE_ALT_ONCE = 2'h3;
   // pattern words
   localparam logic [15:0] PAT_MID = 16'h8000;
   localparam logic [15:0] PAT_POS_FS = 16'hfffc;
   localparam logic [15:0] PAT_NEG_FS = 16'h0000;
   localparam logic [15:0] PAT_CHECK_A = 16'haaa8;
   localparam logic [15:0] PAT_CHECK_B = 16'h5554;
   localparam logic [15:0] PAT_ONES = 16'hfffc;
   localparam logic [15:0] PAT_ZEROS = 16'h0000;
   localparam logic [15:0] PAT_BIT_TOG = 16'haaa8;
   localparam logic [15:0] PAT_SYNC = 16'hff00;
   localparam logic [15:0] PAT_ONE_BIT = 16'h8000;
   localparam logic [15:0] PAT_USER_IDLE = 16'h0000;
   // user pattern sequencer, gray along first-second-done
   typedef enum logic [1:0] {
      USR_FIRST = 2'b00,
      USR_SECOND = 2'b01,
      USR_DONE = 2'b11
   } usr_step_e;
endpackage
`default_nettype wire

/* File: core/adc_output_config_regs.sv */
/*
 * output path configuration bank of a quad converter: divider, chop,
 * test patterns, offset trim, format, driver and output clock phase.
 * assumes a decoded serial port drives the one-cycle write and read
 * strobes with address and data, all synchronous to the sample clock.
 */
`default_nettype none
module adc_output_config_regs (
   input wire logic clock, // sample clock, 50 MHz
   input wire logic reset_n, // async reset, active low
   input wire logic soft_reset, // one-cycle pulse, restores defaults
   input wire logic reg_wr, // register write strobe
   input wire logic reg_rd, // register read strobe
   input wire logic [15:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // register write data
   output logic [7:0] reg_rdata, // read data
   output logic reg_rvalid, // read data valid pulse
   input wire logic [adc_out_cfg_pkg::NUM_CH-1:0]
      [adc_out_cfg_pkg::DATA_W-1:0] sample_data, // converter words
   output logic [adc_out_cfg_pkg::NUM_CH-1:0]
      [adc_out_cfg_pkg::LANE_W-1:0] lane_data, // output lane words
   output logic sample_tick, // divided sample latch pulse
   output logic out_clock_tick, // phase-shifted output clock pulse
   output logic chop_enable, // chop mode on
   output logic lvds_reduced_range, // reduced range signalling
   output logic drive_double, // double drive strength
   output logic [1:0] term_select, // termination code
   output logic [2:0] out_clock_delay, // output clock delay cycles
   output logic [3:0] out_clock_phase_adj // output clock phase code
);
   import adc_out_cfg_pkg::*;

   typedef struct packed {
      logic [5:0] chan_sel; // channel index bits
      logic [2:0] div_ratio; // divide code
      logic chop; // chop mode
      logic [1:0] pn_rst; // long, short generator resets
      logic [NUM_CH-1:0][5:0] tmode; // user mode, test code
      logic [NUM_CH-1:0][7:0] offset; // signed trim
      logic fmt_twos; // twos complement output
      logic [NUM_CH-1:0] invert; // per-channel invert
      logic lvds_ieee; // reduced range option
      logic drive2; // double drive
      logic [1:0] term; // termination
      logic [2:0] ph_dly; // output clock delay
      logic [3:0] ph_adj; // output clock phase adjust
      logic [3:0][7:0] upat; // user pattern bytes
      logic [2:0] div_cnt; // divider count
      logic sample_tick; // latch pulse
      logic oclk_tick; // output clock pulse
      logic alt; // toggles every sample
      usr_step_e [NUM_CH-1:0] ustep; // user sequence step
      logic [NUM_CH-1:0][LANE_W-1:0] lane; // output words
      logic [7:0] rdata; // read data
      logic rvalid; // read valid
   } state_s;

   localparam state_s ST_RST = '{
      chan_sel: CHAN_SEL_RST,
      fmt_twos: OUT_FMT_RST[FMT_BIT],
      ph_dly: OUT_PHASE_RST[6:4],
      ph_adj: OUT_PHASE_RST[3:0],
      ustep: '{default: USR_FIRST},
      default: '0
   };

   state_s q; // registered state
   state_s n; // next state
   logic [2:0] lim; // last divider count
   logic [3:0] ph_pos; // count at which the output clock fires
   logic [1:0] rch; // channel answering reads
   logic signed [15:0] trim_sum; // sample plus trim
   logic [DATA_W-1:0] conv; // trimmed, formatted sample
   logic [LANE_W-1:0] pat; // word chosen for a lane

   pn_gen_if #(.W(PN_LONG_W)) pn_long (); // long sequence
   pn_gen_if #(.W(PN_SHORT_W)) pn_short (); // short sequence

   // generators advance once per divided sample
   assign pn_long.hold = q.pn_rst[1];
   assign pn_short.hold = q.pn_rst[0];
   assign pn_long.step = q.sample_tick;
   assign pn_short.step = q.sample_tick;

   pn_gen #(.W(PN_LONG_W), .TAP(PN_LONG_TAP)) u_pn_long (
      .clock(clock),
      .reset_n(reset_n),
      .port(pn_long.gen)
   );
   pn_gen #(.W(PN_SHORT_W), .TAP(PN_SHORT_TAP)) u_pn_short (
      .clock(clock),
      .reset_n(reset_n),
      .port(pn_short.gen)
   );

   // next state: divider, lanes, register writes and reads
   always_comb begin
      n = q;
      trim_sum = '0;
      conv = '0;
      pat = '0;
      rch = 2'd0;
      // code seven is undefined, held at divide by seven
      lim = (q.div_ratio > DIV_CODE_MAX) ? DIV_CODE_MAX : q.div_ratio;
      // latch point stays at the wrap, only the clock moves
      n.sample_tick = (q.div_cnt >= lim);
      n.div_cnt = n.sample_tick ? 3'h0 : q.div_cnt + 3'h1;
      ph_pos = 4'((4'(lim) + 4'(q.ph_dly)) % (4'(lim) + 4'h1));
      n.oclk_tick = ({1'b0, q.div_cnt} == ph_pos);
      // lanes update one cycle after each latch pulse
      if (q.sample_tick) begin
         n.alt = ~q.alt;
         for (int ch = 0; ch < NUM_CH; ch++) begin
            trim_sum = $signed({2'b00, sample_data[ch]}) +
               $signed({{8{q.offset[ch][7]}}, q.offset[ch]});
            // clamp instead of wrap, a wrapped trim looks like a glitch
            if (trim_sum < 16'sh0000) begin
               conv = '0;
            end else if (trim_sum > $signed({2'b00, DATA_MAX})) begin
               conv = DATA_MAX;
            end else begin
               conv = trim_sum[DATA_W-1:0];
            end
            if (q.fmt_twos) begin
               conv[DATA_W-1] = ~conv[DATA_W-1];
            end
            pat = {conv, 2'b00};
            unique case (q.tmode[ch][3:0])
               TEST_OFF: ; // normal data
               TEST_MID: pat = PAT_MID;
               TEST_POS_FS: pat = PAT_POS_FS;
               TEST_NEG_FS: pat = PAT_NEG_FS;
               TEST_CHECKER: pat = q.alt ? PAT_CHECK_B : PAT_CHECK_A;
               TEST_PN_LONG: pat = pn_long.value[LANE_W-1:0];
               TEST_PN_SHORT: pat = {7'h00, pn_short.value};
               TEST_WORD_TOG: pat = q.alt ? PAT_ZEROS : PAT_ONES;
               TEST_BIT_TOG: pat = PAT_BIT_TOG;
               TEST_SYNC: pat = PAT_SYNC;
               TEST_ONE_BIT: pat = PAT_ONE_BIT;
               TEST_USER: begin
                  unique case (q.ustep[ch])
                     USR_FIRST: pat = {q.upat[1], q.upat[0]};
                     USR_SECOND: pat = {q.upat[3], q.upat[2]};
                     USR_DONE: pat = PAT_USER_IDLE;
                     default: pat = PAT_USER_IDLE; // unused code
                  endcase
                  unique case (q.tmode[ch][5:4])
                     UMODE_REPEAT: n.ustep[ch] = USR_FIRST;
                     UMODE_ALT: begin
                        n.ustep[ch] = (q.ustep[ch] == USR_FIRST) ?
                           USR_SECOND : USR_FIRST;
                     end
                     UMODE_ONCE: n.ustep[ch] = USR_DONE;
                     UMODE_ALT_ONCE: begin
                        n.ustep[ch] = (q.ustep[ch] == USR_FIRST) ?
                           USR_SECOND : USR_DONE;
                     end
                  endcase
               end
               default: ;
            endcase
            n.lane[ch] = pat ^ {LANE_W{q.invert[ch]}};
         end
      end
      // register writes, local fields gated by the channel index
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_CHAN_INDEX: n.chan_sel = reg_wdata[5:0];
            ADDR_CLK_DIV: n.div_ratio = reg_wdata[2:0];
            ADDR_ENH: n.chop = reg_wdata[CHOP_BIT];
            ADDR_TEST: begin
               n.pn_rst = {reg_wdata[PN_LONG_RST_BIT],
                  reg_wdata[PN_SHORT_RST_BIT]};
               for (int ch = 0; ch < NUM_CH; ch++) begin
                  if (q.chan_sel[ch]) begin
                     n.tmode[ch] = {reg_wdata[UMODE_LSB+:2],
                        reg_wdata[3:0]};
                     n.ustep[ch] = USR_FIRST;
                  end
               end
            end
            ADDR_OFFSET: begin
               for (int ch = 0; ch < NUM_CH; ch++) begin
                  if (q.chan_sel[ch]) begin
                     n.offset[ch] = reg_wdata;
                  end
               end
            end
            ADDR_OUT_FMT: begin
               n.fmt_twos = reg_wdata[FMT_BIT];
               n.lvds_ieee = reg_wdata[LVDS_BIT];
               for (int ch = 0; ch < NUM_CH; ch++) begin
                  if (q.chan_sel[ch]) begin
                     n.invert[ch] = reg_wdata[INV_BIT];
                  end
               end
            end
            ADDR_OUT_DRV: begin
               n.drive2 = reg_wdata[DRIVE_BIT];
               n.term = reg_wdata[TERM_LSB+:2];
            end
            ADDR_OUT_PHASE: begin
               n.ph_dly = reg_wdata[PH_DLY_LSB+:3];
               // illegal phase codes are dropped, old phase kept
               if (reg_wdata[3:0] <= PHASE_ADJ_MAX) begin
                  n.ph_adj = reg_wdata[3:0];
               end
            end
            ADDR_UPAT1_LO: n.upat[0] = reg_wdata;
            ADDR_UPAT1_HI: n.upat[1] = reg_wdata;
            ADDR_UPAT2_LO: n.upat[2] = reg_wdata;
            ADDR_UPAT2_HI: n.upat[3] = reg_wdata;
            default: ; // unmapped write ignored
         endcase
      end
      // lowest selected data channel answers local reads
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (q.chan_sel[i]) begin
            rch = 2'(i);
         end
      end
      n.rvalid = reg_rd;
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_CHAN_INDEX: n.rdata = {2'b00, q.chan_sel};
            ADDR_CLK_DIV: n.rdata = {5'h00, q.div_ratio};
            ADDR_ENH: n.rdata = {5'h00, q.chop, 2'b00};
            ADDR_TEST: begin
               n.rdata = {q.tmode[rch][5:4], q.pn_rst, q.tmode[rch][3:0]};
            end
            ADDR_OFFSET: n.rdata = q.offset[rch];
            ADDR_OUT_FMT: begin
               n.rdata = {1'b0, q.lvds_ieee, 3'h0, q.invert[rch], 1'b0,
                  q.fmt_twos};
            end
            ADDR_OUT_DRV: n.rdata = {2'b00, q.term, 3'h0, q.drive2};
            ADDR_OUT_PHASE: n.rdata = {1'b0, q.ph_dly, q.ph_adj};
            ADDR_UPAT1_LO: n.rdata = q.upat[0];
            ADDR_UPAT1_HI: n.rdata = q.upat[1];
            ADDR_UPAT2_LO: n.rdata = q.upat[2];
            ADDR_UPAT2_HI: n.rdata = q.upat[3];
            default: n.rdata = 8'h00; // unmapped reads zero
         endcase
      end
      // soft reset beats any access in the same cycle
      if (soft_reset) begin
         n = ST_RST;
      end
   end

   // single state register
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         q <= ST_RST;
      end else begin
         q <= n;
      end
   end

   assign reg_rdata = q.rdata;
   assign reg_rvalid = q.rvalid;
   assign lane_data = q.lane;
   assign sample_tick = q.sample_tick;
   assign out_clock_tick = q.oclk_tick;
   assign chop_enable = q.chop;
   assign lvds_reduced_range = q.lvds_ieee;
   assign drive_double = q.drive2;
   assign term_select = q.term;
   assign out_clock_delay = q.ph_dly;
   assign out_clock_phase_adj = q.ph_adj;

   // checks on the logic above
   property p_div2;
      @(posedge clock) disable iff (!reset_n || soft_reset)
      (q.sample_tick && q.div_ratio == 3'h1 && !reg_wr) |=>
         !q.sample_tick ##1 q.sample_tick;
   endproperty
   a_div2: assert property (p_div2)
      else $error("divide by two spacing wrong");
   property p_chop;
      @(posedge clock) disable iff (!reset_n)
      (reg_wr && reg_addr == ADDR_ENH && !soft_reset) |=>
         chop_enable == $past(reg_wdata[CHOP_BIT]);
   endproperty
   a_chop: assert property (p_chop)
      else $error("chop bit not taken");
   property p_pos_fs;
      @(posedge clock) disable iff (!reset_n || soft_reset)
      (q.sample_tick && q.tmode[0][3:0] == TEST_POS_FS) |=>
         lane_data[0] == (PAT_POS_FS ^ {LANE_W{$past(q.invert[0])}});
   endproperty
   a_pos_fs: assert property (p_pos_fs)
      else $error("positive full scale pattern wrong");
   property p_pn_hold;
      @(posedge clock) disable iff (!reset_n)
      q.pn_rst[1] |=> pn_long.value == '1;
   endproperty
   a_pn_hold: assert property (p_pn_hold)
      else $error("long generator not held at seed");
   property p_user_once;
      @(posedge clock) disable iff (!reset_n || soft_reset)
      (q.sample_tick && q.tmode[0] == {UMODE_ONCE, TEST_USER} &&
         q.ustep[0] == USR_DONE) |=>
         lane_data[0] == (PAT_USER_IDLE ^ {LANE_W{$past(q.invert[0])}});
   endproperty
   a_user_once: assert property (p_user_once)
      else $error("single user pattern repeated");
   property p_local_gate;
      @(posedge clock) disable iff (!reset_n || soft_reset)
      (reg_wr && reg_addr == ADDR_OUT_FMT && !q.chan_sel[1]) |=>
         $stable(q.invert[1]);
   endproperty
   a_local_gate: assert property (p_local_gate)
      else $error("unselected channel written");
   property p_phase_adj;
      @(posedge clock) disable iff (!reset_n || soft_reset)
      (reg_wr && reg_addr == ADDR_OUT_PHASE &&
         reg_wdata[3:0] > PHASE_ADJ_MAX) |=> $stable(out_clock_phase_adj);
   endproperty
   a_phase_adj: assert property (p_phase_adj)
      else $error("illegal phase code stored");
   property p_phase_zero;
      @(posedge clock) disable iff (!reset_n || soft_reset)
      // a count left above a lowered ratio wraps without the clock
      (q.ph_dly == 3'h0 && $stable(q.ph_dly) && $stable(q.div_ratio) &&
         $past(q.div_cnt) <= q.div_ratio)
         |-> (sample_tick == out_clock_tick);
   endproperty
   a_phase_zero: assert property (p_phase_zero)
      else $error("zero delay clock off the latch point");
   property p_term;
      @(posedge clock) disable iff (!reset_n)
      (reg_wr && reg_addr == ADDR_OUT_DRV && !soft_reset) |=>
         term_select == $past(reg_wdata[TERM_LSB+:2]);
   endproperty
   a_term: assert property (p_term)
      else $error("termination field not taken");
   property p_upat_rd;
      @(posedge clock) disable iff (!reset_n || soft_reset)
      (reg_rd && reg_addr == ADDR_UPAT1_LO) |=>
         reg_rvalid && reg_rdata == $past(q.upat[0]);
   endproperty
   a_upat_rd: assert property (p_upat_rd)
      else $error("user pattern readback wrong");
endmodule // adc_output_config_regs
`default_nettype wire

/* File: core/pn_gen.sv */
/*
 * fibonacci shift register generator, length and tap set by parameters.
 * assumes hold and step are synchronous to clock.
 */
`default_nettype none
module pn_gen #(
   parameter int W = 23, // register length
   parameter int TAP = 18 // second feedback tap
) (
   input wire logic clock, // system clock
   input wire logic reset_n, // async reset, active low
   pn_gen_if.gen port // control and state
);
   typedef struct packed {
      logic [W-1:0] sr; // shift register
   } state_s;
   state_s q; // registered state
   state_s n; // next state
   // all ones seed, the all-zero lock state is never reached
   always_comb begin
      n = q;
      if (port.hold) begin
         n.sr = '1;
      end else if (port.step) begin
         n.sr = {q.sr[W-2:0], q.sr[W-1] ^ q.sr[TAP-1]};
      end
   end
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         q <= '1;
      end else begin
         q <= n;
      end
   end
   assign port.value = q.sr;
endmodule // pn_gen
`default_nettype wire

/* File: core/pn_gen_if.sv */
/*
 * carrier between the bank and one pseudorandom generator.
 * assumes hold and step come from registered state of the bank.
 */
`default_nettype none
interface pn_gen_if #(parameter int W = 23);
   logic hold; // keep generator at its seed
   logic step; // advance one state
   logic [W-1:0] value; // current generator state
   modport gen (input hold, input step, output value);
   modport user (output hold, output step, input value);
endinterface
`default_nettype wire

/* File: dv/adc_output_config_regs_test.sv */
/* self-checking bench for the output configuration bank.
   assumes the host model is the only register bus driver. */
`default_nettype none
module adc_output_config_regs_test;
   timeunit 1ns;
   timeprecision 100ps;
   import adc_out_cfg_pkg::*;
   logic clock, reset_n, soft_reset, reg_wr, reg_rd, reg_rvalid;
   logic sample_tick, out_clock_tick, chop_enable, lvds_reduced_range;
   logic drive_double;
   logic [1:0] term_select;
   logic [2:0] out_clock_delay;
   logic [3:0] out_clock_phase_adj, adj;
   logic [15:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic [NUM_CH-1:0][DATA_W-1:0] sample_data;
   logic [NUM_CH-1:0][LANE_W-1:0] lane_data;
   logic [13:0] s;
   logic [15:0] p1, p2, w;
   logic [15:0] tx[3]; // expected xor of two successive words
   logic [7:0] tcode[3] = '{8'h04, 8'h07, 8'h48}; // alternating codes
   int n_mismatch = 0, n_compared = 0, cycles = 0, n;
   // reset table: address and default, last entry unmapped
   logic [15:0] adr[12] = '{ADDR_CLK_DIV, ADDR_ENH, ADDR_TEST, ADDR_OFFSET,
      ADDR_OUT_FMT, ADDR_OUT_DRV, ADDR_OUT_PHASE, ADDR_UPAT1_LO,
      ADDR_UPAT1_HI, ADDR_UPAT2_LO, ADDR_UPAT2_HI, 16'h0030};
   logic [7:0] rst[12] = '{0, 0, 0, 0, 8'h01, 0, 8'h03, 0, 0, 0, 0, 0};
   // test byte and expected lane word; pn codes hold generator at seed
   logic [7:0] code[8] = '{8'h01, 8'h02, 8'h03, 8'h0a, 8'h0b, 8'h09,
      8'h25, 8'h16};
   logic [15:0] pat[8] = '{16'h8000, 16'hfffc, 16'h0000, 16'hff00,
      16'h8000, 16'haaa8, 16'hffff, 16'h01ff};
   adc_output_config_regs uut (.clock(clock), .reset_n(reset_n),
      .soft_reset(soft_reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .sample_data(sample_data),
      .lane_data(lane_data), .sample_tick(sample_tick),
      .out_clock_tick(out_clock_tick), .chop_enable(chop_enable),
      .lvds_reduced_range(lvds_reduced_range), .drive_double(drive_double),
      .term_select(term_select), .out_clock_delay(out_clock_delay),
      .out_clock_phase_adj(out_clock_phase_adj));
   cfg_host_model host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   task automatic check(input string what, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // read watcher; each read is checked against the value its host.rd call queued
   always @(posedge clock) if (reg_rvalid === 1'b1) begin
      if (host.exp_q.size() == 0) check("stray read", 16'h1, 16'h0);
      else check("read data", 16'(reg_rdata), 16'(host.exp_q.pop_front()));
   end
   // hang guard, run needs well under a thousand cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         complete_run();
      end
   end
   initial begin
      reset_n = 1'b0;
      soft_reset = 1'b0;
      sample_data = '0;
      void'($urandom(32'h6e7deab3));
      repeat (2) @(posedge clock);
      #1 reset_n = 1'b1;
      for (int i = 0; i < 12; i++) host.rd(adr[i], rst[i]);
      check("phase adj", 16'(out_clock_phase_adj), 16'h3);
      $display("reset values done");
      d = 8'($urandom);
      adj = 4'($urandom % 12);
      host.wr(ADDR_ENH, d);
      host.wr(ADDR_OUT_DRV, d);
      host.wr(ADDR_OUT_FMT, (d & 8'hfb) | 8'h01);
      host.wr(ADDR_OUT_PHASE, {1'b0, d[6:4], adj});
      host.rd(ADDR_ENH, d & 8'h04);
      host.rd(ADDR_OUT_DRV, d & 8'h31);
      host.rd(ADDR_OUT_FMT, (d & 8'h40) | 8'h01);
      check("chop", 16'(chop_enable), 16'(d[2]));
      check("term", 16'(term_select), 16'(d[5:4]));
      check("drive", 16'(drive_double), 16'(d[0]));
      check("lvds", 16'(lvds_reduced_range), 16'(d[6]));
      check("delay", 16'(out_clock_delay), 16'(d[6:4]));
      host.wr(ADDR_OUT_PHASE, 8'h5c);
      check("adj kept", 16'(out_clock_phase_adj), 16'(adj));
      host.rd(ADDR_OUT_PHASE, {4'h5, adj});
      $display("field writes done");
      host.wr(ADDR_CLK_DIV, 8'h03);
      n = 0;
      repeat (40) @(posedge clock) n += int'(sample_tick === 1'b1);
      check("sample ticks", 16'(n), 16'd10);
      n = 0;
      repeat (40) @(posedge clock) n += int'(out_clock_tick === 1'b1);
      check("clock ticks", 16'(n), 16'd10);
      host.wr(ADDR_CLK_DIV, 8'h01);
      n = 0;
      repeat (20) @(posedge clock) n += int'(sample_tick === 1'b1);
      check("div two ticks", 16'(n), 16'd10);
      host.wr(ADDR_CLK_DIV, 8'h00);
      $display("divider done");
      for (int i = 0; i < 8; i++) begin
         host.wr(ADDR_TEST, code[i]);
         repeat (4) @(posedge clock);
         check("pattern", lane_data[i % 4], pat[i]);
      end
      p1 = 16'($urandom);
      p2 = 16'($urandom);
      host.wr(ADDR_UPAT1_LO, p1[7:0]);
      host.wr(ADDR_UPAT1_HI, p1[15:8]);
      host.wr(ADDR_UPAT2_LO, p2[7:0]);
      host.wr(ADDR_UPAT2_HI, p2[15:8]);
      host.rd(ADDR_UPAT2_HI, p2[15:8]);
      host.wr(ADDR_TEST, 8'h08);
      repeat (6) @(posedge clock);
      check("user repeat", lane_data[3], p1);
      host.wr(ADDR_TEST, 8'h88);
      repeat (6) @(posedge clock);
      check("user once", lane_data[3], PAT_USER_IDLE);
      host.wr(ADDR_TEST, 8'hc8);
      @(posedge clock) #1 check("alt once 1", lane_data[2], p1);
      @(posedge clock) #1 check("alt once 2", lane_data[2], p2);
      repeat (2) @(posedge clock);
      check("alt once end", lane_data[2], PAT_USER_IDLE);
      // checker, word toggle and user alternate flip every sample
      tx = '{PAT_CHECK_A ^ PAT_CHECK_B, PAT_ONES ^ PAT_ZEROS, p1 ^ p2};
      for (int i = 0; i < 3; i++) begin
         host.wr(ADDR_TEST, tcode[i]);
         repeat (3) @(posedge clock);
         #1 w = lane_data[0];
         @(posedge clock) #1 w = w ^ lane_data[0];
         check("alternation", w, tx[i]);
      end
      $display("patterns done");
      s = 14'h0100 + 14'($urandom % 15616);
      sample_data = {4{s}};
      host.wr(ADDR_TEST, 8'h0c);
      host.wr(ADDR_CHAN_INDEX, 8'h02);
      host.wr(ADDR_OFFSET, 8'h85);
      host.wr(ADDR_OUT_FMT, 8'h04);
      repeat (4) @(posedge clock);
      check("lane a", lane_data[0], {s, 2'b00});
      check("lane b", lane_data[1], ~{14'(s - 14'd123), 2'b00});
      host.rd(ADDR_OFFSET, 8'h85);
      host.wr(ADDR_CHAN_INDEX, 8'h01);
      host.rd(ADDR_OFFSET, 8'h00);
      host.wr(ADDR_OUT_FMT, 8'h01);
      repeat (4) @(posedge clock);
      check("lane c", lane_data[2], {~s[13], s[12:0], 2'b00});
      $display("data path done");
      @(posedge clock) #1 soft_reset = 1'b1;
      @(posedge clock) #1 soft_reset = 1'b0;
      host.rd(ADDR_OUT_PHASE, 8'h03);
      host.rd(ADDR_OUT_FMT, 8'h01);
      repeat (4) @(posedge clock);
      check("reads left", 16'(host.exp_q.size()), 16'h0);
      $display("soft reset done");
      complete_run();
   end
endmodule // adc_output_config_regs_test
`default_nettype wire

/* File: dv/cfg_host_model.sv */
/* host model: drives one-cycle register strobes on the sample clock.
   assumes the bench pops exp_q each time read data turns valid. */
`default_nettype none
module cfg_host_model (
   input wire logic clock, // sample clock
   output logic reg_wr, // write strobe
   output logic reg_rd, // read strobe
   output logic [15:0] reg_addr, // register address
   output logic [7:0] reg_wdata // write data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] exp_q[$]; // expected read data, oldest first
   // idle bus at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
   end
   // one strobe per transfer, held across exactly one sampling edge
   task automatic xfer(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
      @(posedge clock);
      #1;
      reg_wr = w;
      reg_rd = !w;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clock);
      #1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask
   // note expected data before the strobe so the watcher finds it
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 8'h00);
   endtask
endmodule // cfg_host_model
`default_nettype wire
